// [logic/spl_pkg.sv]
package spl_pkg;

   // Serial command decode
   localparam logic [7:0]  OPC_READ_PROT    = 8'h3C;
   localparam int          OPC_BITS         = 8;
   localparam int          ADDR_BITS        = 24;
   localparam logic [4:0]  OPC_LAST_BIT     = 5'h07;
   localparam logic [4:0]  ADDR_LAST_BIT    = 5'h17;

   // Sector geometry: 128 sectors selected by address bits 22..16
   localparam int          SECTOR_BITS      = 7;
   localparam int          NUM_SECTORS      = 128;
   localparam int          SECTOR_LSB       = 16;

   // First status byte layout
   localparam int          LOCK_BIT         = 7;
   localparam int          GLOBAL_MSB       = 5;
   localparam int          GLOBAL_LSB       = 2;
   localparam logic [3:0]  GLOBAL_PROTECT   = 4'hF;
   localparam logic [3:0]  GLOBAL_UNPROTECT = 4'h0;

   // Reset values
   localparam logic        LOCK_RESET       = 1'b0;
   localparam logic        PROT_RESET       = 1'b1;

   // Software protection summary encoding
   localparam logic [1:0]  SUMMARY_NONE     = 2'h0;
   localparam logic [1:0]  SUMMARY_SOME     = 2'h1;
   localparam logic [1:0]  SUMMARY_ALL      = 2'h3;

   typedef enum logic [2:0] {
      SPL_IDLE   = 3'b000,
      SPL_OPCODE = 3'b001,
      SPL_ADDR   = 3'b011,
      SPL_OUTPUT = 3'b010,
      SPL_SKIP   = 3'b110
   } spl_state_t;

   typedef struct packed {
      logic                   valid;
      logic                   protect;
      logic [SECTOR_BITS-1:0] sector;
   } spl_sec_cmd_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } spl_stat_wr_t;

endpackage

// [logic/spl_prot_mem.sv]
`timescale 1ns/1ps
module spl_prot_mem (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            rstn,
   // Single bit write
   input  wire logic                            wr_en,
   input  wire logic [spl_pkg::SECTOR_BITS-1:0] wr_addr,
   input  wire logic                            wr_data,
   // Whole array fill
   input  wire logic                            fill_en,
   input  wire logic                            fill_val,
   // Registered read and summary
   input  wire logic [spl_pkg::SECTOR_BITS-1:0] rd_addr,
   output logic                                 rd_data,
   output logic                                 all_set,
   output logic                                 any_set
);

   logic [spl_pkg::NUM_SECTORS-1:0] prot_reg;

   // Every sector powers up protected
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prot_reg <= {spl_pkg::NUM_SECTORS{spl_pkg::PROT_RESET}};
      end else if (fill_en) begin
         prot_reg <= {spl_pkg::NUM_SECTORS{fill_val}};
      end else if (wr_en) begin
         prot_reg[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_data <= spl_pkg::PROT_RESET;
         all_set <= 1'b1;
         any_set <= 1'b1;
      end else begin
         rd_data <= prot_reg[rd_addr];
         all_set <= &prot_reg;
         any_set <= |prot_reg;
      end
   end

endmodule

// [logic/spl_lock_read.sv]
// Function
// - Opcode 3Ch starts protection read.
// - Three address bytes follow the opcode.
// - Output bit every clock after address.
// - Repeat 00h unprotected, FFh protected.
// - Chip select release ends read, floats output.
// - Release allowed at any bit position.
// - Read byte ignores write-protect pin.
// - Summary bits report all, some, none.
// - Pin never changes protection directly.
// - Hardware lock needs pin and lock bit.
// - Hardware lock freezes bits, ignores commands.
// - Clearing lock bit skips global operation.
// - Pin held asserted: lock clears only by power.
// - Power-up: all protected, lock bit clear.
// - Software lock ignores sector commands.
// - Setting lock bit also decodes global operation.
// - Lock bit settable from 0 always.
// - Software lock lets lock bit clear.
// - Lock bit 1 blocks global operations.
// - Lock bit 0 lets commands modify bits.
// - 00h unprotects all, 7Fh protects all.
// - Store bit seven only; decode bits five-two.
`timescale 1ns/1ps
module spl_lock_read (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // Serial pins
   input  wire logic                  cs_n,
   input  wire logic                  sck,
   input  wire logic                  si,
   output logic                       so,
   output logic                       so_oe_n,
   // Write-protect pin
   input  wire logic                  wp_n,
   // Protection commands from the decoder
   input  wire spl_pkg::spl_sec_cmd_t sec_cmd,
   input  wire spl_pkg::spl_stat_wr_t stat_wr,
   // Status
   output logic                       protection_lock_bit,
   output logic                       hw_locked,
   output logic [1:0]                 software_protect_summary
);

   // Pin synchronisers, two flops each
   logic [1:0]                      cs_sync_reg;
   logic [1:0]                      sck_sync_reg;
   logic [1:0]                      si_sync_reg;
   logic [1:0]                      wp_sync_reg;
   logic                            sck_last_reg;
   logic                            cs_act;
   logic                            sck_rise;
   logic                            sck_fall;
   logic                            wp_asserted;

   spl_pkg::spl_state_t             state_reg;
   logic [4:0]                      bit_cnt_reg;
   logic [spl_pkg::ADDR_BITS-1:0]   shift_reg;
   logic [spl_pkg::ADDR_BITS-1:0]   shift_next;
   logic [spl_pkg::SECTOR_BITS-1:0] sector_reg;

   logic                            lock_reg;
   logic                            mem_rd;
   logic                            mem_all;
   logic                            mem_any;
   logic                            hw_lock;
   logic [3:0]                      global_code;
   logic                            global_en;
   logic                            sector_en;

   function automatic logic [spl_pkg::ADDR_BITS-1:0] shift_in(
      input logic [spl_pkg::ADDR_BITS-1:0] cur,
      input logic                          bit_in
   );
      shift_in = {cur[spl_pkg::ADDR_BITS-2:0], bit_in};
   endfunction

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cs_sync_reg  <= 2'h3;
         sck_sync_reg <= 2'h0;
         si_sync_reg  <= 2'h0;
         wp_sync_reg  <= 2'h3;
         sck_last_reg <= 1'b0;
      end else begin
         cs_sync_reg  <= {cs_sync_reg[0], cs_n};
         sck_sync_reg <= {sck_sync_reg[0], sck};
         si_sync_reg  <= {si_sync_reg[0], si};
         wp_sync_reg  <= {wp_sync_reg[0], wp_n};
         sck_last_reg <= sck_sync_reg[1];
      end
   end

   // Edges are only trusted while chip select is held
   assign cs_act      = ~cs_sync_reg[1];
   assign sck_rise    = cs_act & sck_sync_reg[1] & ~sck_last_reg;
   assign sck_fall    = cs_act & ~sck_sync_reg[1] & sck_last_reg;
   assign wp_asserted = ~wp_sync_reg[1];
   assign shift_next  = shift_in(shift_reg, si_sync_reg[1]);

   // Command and address capture
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg   <= spl_pkg::SPL_IDLE;
         bit_cnt_reg <= 5'h00;
         shift_reg   <= '0;
         sector_reg  <= '0;
      end else if (!cs_act) begin
         state_reg   <= spl_pkg::SPL_IDLE;
         bit_cnt_reg <= 5'h00;
      end else begin
         unique case (state_reg)
            spl_pkg::SPL_IDLE: begin
               state_reg   <= spl_pkg::SPL_OPCODE;
               bit_cnt_reg <= 5'h00;
            end
            spl_pkg::SPL_OPCODE: begin
               if (sck_rise) begin
                  shift_reg <= shift_next;
                  if (bit_cnt_reg == spl_pkg::OPC_LAST_BIT) begin
                     bit_cnt_reg <= 5'h00;
                     // Other opcodes belong to other blocks
                     if (shift_next[spl_pkg::OPC_BITS-1:0] == spl_pkg::OPC_READ_PROT) begin
                        state_reg <= spl_pkg::SPL_ADDR;
                     end else begin
                        state_reg <= spl_pkg::SPL_SKIP;
                     end
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  end
               end
            end
            spl_pkg::SPL_ADDR: begin
               if (sck_rise) begin
                  shift_reg <= shift_next;
                  if (bit_cnt_reg == spl_pkg::ADDR_LAST_BIT) begin
                     sector_reg <= shift_next[spl_pkg::SECTOR_LSB +: spl_pkg::SECTOR_BITS];
                     state_reg  <= spl_pkg::SPL_OUTPUT;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  end
               end
            end
            spl_pkg::SPL_OUTPUT: begin
               state_reg <= spl_pkg::SPL_OUTPUT;
            end
            spl_pkg::SPL_SKIP: begin
               state_reg <= spl_pkg::SPL_SKIP;
            end
            default: begin
               state_reg <= spl_pkg::SPL_IDLE;
            end
         endcase
      end
   end

   // Output driver: every bit of the byte equals the protection bit
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         so      <= 1'b0;
         so_oe_n <= 1'b1;
      end else if (!cs_act) begin
         so      <= 1'b0;
         so_oe_n <= 1'b1;
      end else if (state_reg == spl_pkg::SPL_OUTPUT && sck_fall) begin
         so      <= mem_rd;
         so_oe_n <= 1'b0;
      end
   end

   // Lock evaluation and protection updates
   assign hw_lock     = wp_asserted & lock_reg;
   assign global_code = stat_wr.data[spl_pkg::GLOBAL_MSB:spl_pkg::GLOBAL_LSB];
   // Global acts only from an unlocked state; clearing the lock never does it
   assign global_en   = stat_wr.valid & ~lock_reg &
                        ((global_code == spl_pkg::GLOBAL_PROTECT) ||
                         (global_code == spl_pkg::GLOBAL_UNPROTECT));
   // A global operation in the same cycle takes precedence over a sector command
   assign sector_en   = sec_cmd.valid & ~lock_reg & ~global_en;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lock_reg <= spl_pkg::LOCK_RESET;
      end else if (stat_wr.valid && !hw_lock) begin
         lock_reg <= stat_wr.data[spl_pkg::LOCK_BIT];
      end
   end

   // The pin reaches the array only through the lock decision
   spl_prot_mem u_mem (
      .clock    (clock),
      .rstn     (rstn),
      .wr_en    (sector_en),
      .wr_addr  (sec_cmd.sector),
      .wr_data  (sec_cmd.protect),
      .fill_en  (global_en),
      .fill_val (global_code == spl_pkg::GLOBAL_PROTECT),
      .rd_addr  (sector_reg),
      .rd_data  (mem_rd),
      .all_set  (mem_all),
      .any_set  (mem_any)
   );

   // Status outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         protection_lock_bit      <= spl_pkg::LOCK_RESET;
         hw_locked                <= 1'b0;
         software_protect_summary <= spl_pkg::SUMMARY_ALL;
      end else begin
         protection_lock_bit <= lock_reg;
         hw_locked           <= hw_lock;
         if (mem_all) begin
            software_protect_summary <= spl_pkg::SUMMARY_ALL;
         end else if (mem_any) begin
            software_protect_summary <= spl_pkg::SUMMARY_SOME;
         end else begin
            software_protect_summary <= spl_pkg::SUMMARY_NONE;
         end
      end
   end

endmodule

// [dv/spl_host_model.sv]
`timescale 1ns/1ps
module spl_host_model (
   // Serial pins
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe_n
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // Mode 0 frame, MSB first, 125 ns bit time; a floating output samples as unknown
   task automatic frame(input logic [31:0] cmd, input int nout, output logic [15:0] rx);
      rx = 16'h0000;
      cs_n = 1'b0;
      #100;
      for (int i = 0; i < 32 + nout; i++) begin
         if (i < 32)
            si = cmd[31-i];
         #62.5 sck = 1'b1;
         if (i >= 32)
            rx = {rx[14:0], so_oe_n ? 1'bx : so};
         #62.5 sck = 1'b0;
         if (i == 31)
            si = ~si;
      end
      // Released data line shows the inverse so a stale level never passes
      #62.5 cs_n = 1'b1;
      si = ~si;
      #100;
   endtask
endmodule

// [dv/spl_lock_read_assertions.sv]
`timescale 1ns/1ps
module spl_lock_read_checker (
   input wire logic                  clock,
   input wire logic                  rstn,
   input wire logic                  cs_n,
   input wire logic                  so,
   input wire logic                  so_oe_n,
   input wire logic                  wp_n,
   input wire spl_pkg::spl_stat_wr_t stat_wr,
   input wire logic                  protection_lock_bit,
   input wire logic                  hw_locked,
   input wire logic [1:0]            software_protect_summary
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   oe_release_a: assert property (cs_n [*6] |-> so_oe_n)
      else $error("output driven after deselect");
   so_parked_a: assert property (so_oe_n |-> !so)
      else $error("data out not parked");
   oe_needs_cs_a: assert property (!so_oe_n |-> !$past(cs_n, 5))
      else $error("output driven without select");
   hw_set_a: assert property ((!wp_n && protection_lock_bit) [*6] |-> hw_locked)
      else $error("hardware lock missing");
   hw_clear_a: assert property (wp_n [*6] |-> !hw_locked)
      else $error("hardware lock with pin high");
   hw_needs_lock_a: assert property (hw_locked |-> protection_lock_bit)
      else $error("hardware lock without lock bit");
   lock_hold_a: assert property ((!wp_n) [*6] ##0 protection_lock_bit |=> protection_lock_bit)
      else $error("lock bit cleared under pin");
   lock_set_a: assert property (stat_wr.valid && stat_wr.data[spl_pkg::LOCK_BIT] && !protection_lock_bit
      |-> ##[1:3] protection_lock_bit) else $error("lock bit not set");
   prot_frozen_a: assert property (protection_lock_bit && $past(protection_lock_bit)
      && $past(protection_lock_bit, 2) |=> $stable(software_protect_summary))
      else $error("protection changed while locked");
endmodule
bind spl_lock_read spl_lock_read_checker chk (.clock(clock), .rstn(rstn), .cs_n(cs_n), .so(so), .so_oe_n(so_oe_n),
   .wp_n(wp_n), .stat_wr(stat_wr), .protection_lock_bit(protection_lock_bit), .hw_locked(hw_locked),
   .software_protect_summary(software_protect_summary));

// [dv/tb_spl_lock_read.sv]
`timescale 1ns/1ps
module tb_spl_lock_read;
   localparam logic [7:0] OP   = spl_pkg::OPC_READ_PROT;
   localparam logic [1:0] ALL  = spl_pkg::SUMMARY_ALL;
   localparam logic [1:0] SOME = spl_pkg::SUMMARY_SOME;
   localparam logic [1:0] NONE = spl_pkg::SUMMARY_NONE;
   logic                  clock, rstn, cs_n, sck, si, so, so_oe_n, wp_n, protection_lock_bit, hw_locked;
   logic [1:0]            software_protect_summary;
   spl_pkg::spl_sec_cmd_t sec_cmd;
   spl_pkg::spl_stat_wr_t stat_wr;
   logic [15:0]           rx;
   int                    failures, total_checks;
   spl_lock_read uut (.clock(clock), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n),
      .wp_n(wp_n), .sec_cmd(sec_cmd), .stat_wr(stat_wr), .protection_lock_bit(protection_lock_bit),
      .hw_locked(hw_locked), .software_protect_summary(software_protect_summary));
   spl_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_state(input logic lock, input logic [1:0] summ);
      check(16'(protection_lock_bit), 16'(lock));
      check(16'(software_protect_summary), 16'(summ));
   endtask
   // Every frame also confirms the output floats again after deselect
   task automatic read(input logic [31:0] cmd, input int n, input logic [15:0] exp);
      host.frame(cmd, n, rx);
      check(rx, exp);
      check(16'(so_oe_n), 16'h0001);
   endtask
   task automatic stat(input logic [7:0] d);
      @(posedge clock);
      stat_wr <= {1'b1, d};
      @(posedge clock);
      stat_wr <= {1'b0, d};
      repeat (6) @(posedge clock);
   endtask
   task automatic sec(input logic p, input logic [6:0] s);
      @(posedge clock);
      sec_cmd <= {1'b1, p, s};
      @(posedge clock);
      sec_cmd <= {1'b0, p, s};
      repeat (6) @(posedge clock);
   endtask
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200_000;
      failures++;
      conclude();
   end
   initial begin
      rstn = 1'b0;
      wp_n = 1'b1;
      sec_cmd = '0;
      stat_wr = '0;
      failures = 0;
      total_checks = 0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      check_state(1'b0, ALL);
      read({OP, 8'h85, 16'hA5C3}, 16, 16'hFFFF);
      sec(1'b0, 7'h05);
      check_state(1'b0, SOME);
      read({OP, 8'h05, 16'h0000}, 16, 16'h0000);
      sec(1'b1, 7'h05);
      check_state(1'b0, ALL);
      read({OP, 8'h06, 16'hFFFF}, 3, 16'h0007);
      read({8'h3D, 8'h05, 16'h0000}, 16, 16'hxxxx);
      stat(8'h00);
      check_state(1'b0, NONE);
      // Global write and sector command in one cycle: the global one wins
      @(posedge clock);
      stat_wr <= {1'b1, 8'h7F};
      sec_cmd <= {1'b1, 1'b0, 7'h05};
      @(posedge clock);
      stat_wr <= '0;
      sec_cmd <= '0;
      repeat (6) @(posedge clock);
      check_state(1'b0, ALL);
      stat(8'h7F);
      check_state(1'b0, ALL);
      sec(1'b0, 7'h05);
      wp_n <= 1'b0;
      stat(8'hF0);
      check_state(1'b1, SOME);
      check(16'(hw_locked), 16'h0001);
      read({OP, 8'h05, 16'h1234}, 16, 16'h0000);
      sec(1'b1, 7'h05);
      stat(8'h00);
      check_state(1'b1, SOME);
      wp_n <= 1'b1;
      repeat (6) @(posedge clock);
      check(16'(hw_locked), 16'h0000);
      sec(1'b1, 7'h05);
      stat(8'hFF);
      check_state(1'b1, SOME);
      stat(8'h3C);
      check_state(1'b0, SOME);
      stat(8'h80);
      check_state(1'b1, NONE);
      // Pin held low: only a power cycle drops the lock bit
      wp_n <= 1'b0;
      repeat (6) @(posedge clock);
      check(16'(hw_locked), 16'h0001);
      stat(8'h0F);
      check_state(1'b1, NONE);
      rstn <= 1'b0;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      check_state(1'b0, ALL);
      check(16'(hw_locked), 16'h0000);
      read({OP, 8'h05, 16'h0000}, 16, 16'hFFFF);
      conclude();
   end
endmodule
